// >>> verilog/rpgs_pkg.sv
// shared constants and types for rail power-good and sequencing
package rpgs_pkg;
    localparam int unsigned CLK_PERIOD_PS = 8000;
    localparam int unsigned MS_IN_PS = 1000000000;
    localparam int unsigned MS_CYCLES = MS_IN_PS / CLK_PERIOD_PS;

    localparam logic [7:0] ADDR_STATUS = 8'h0B;
    localparam logic [7:0] ADDR_MASK = 8'h0C;
    localparam logic [7:0] ADDR_CTRL = 8'h0D;

    localparam int STAT_RESET_BIT = 7;
    localparam int DLY_HI = 6;
    localparam int DLY_LO = 5;
    localparam int SEQ_HI = 7;
    localparam int SEQ_LO = 5;
    localparam int MASK_PAIR_BIT = 5;

    localparam int RAIL_B1 = 4;
    localparam int RAIL_B2 = 3;
    localparam int RAIL_B3 = 2;
    localparam int RAIL_LR1 = 1;
    localparam int RAIL_LR2 = 0;
    localparam int GRP_EXT = 5;

    localparam logic [1:0] DLY_DEFAULT = 2'h3;
    localparam logic [5:0] MASK_DEFAULT = 6'h08;
    localparam logic [4:0] ENA_DEFAULT = 5'h1F;
    localparam logic [2:0] SEQ_DEFAULT = 3'h0;

    localparam logic [1:0] DLY_20 = 2'h0;
    localparam logic [1:0] DLY_100 = 2'h1;
    localparam logic [1:0] DLY_200 = 2'h2;
    localparam logic [8:0] DLY20_MS = 9'h014;
    localparam logic [8:0] DLY100_MS = 9'h064;
    localparam logic [8:0] DLY200_MS = 9'h0C8;
    localparam logic [8:0] DLY400_MS = 9'h190;

    localparam logic [2:0] SEQ_B2 = 3'h0;
    localparam logic [2:0] SEQ_B2B3 = 3'h1;
    localparam logic [2:0] SEQ_B1_B2B3 = 3'h2;
    localparam logic [2:0] SEQ_B3_B2 = 3'h3;
    localparam logic [2:0] SEQ_LR2_B1B2 = 3'h4;
    localparam logic [2:0] SEQ_PINS = 3'h5;
    localparam logic [2:0] SEQ_B1_B2_B3 = 3'h6;
    localparam logic [2:0] SEQ_EXT_LR2_B1B2 = 3'h7;

    localparam logic [1:0] LVL_MAX = 2'h3;
    localparam logic [1:0] LVL_GAP = 2'h2;
    localparam logic [1:0] SEQ_GAP_TICKS = 2'h2;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rpgs_regreq_t;

    typedef enum logic [3:0] {
        SQ_OFF = 4'h1,
        SQ_RISE = 4'h2,
        SQ_HOLD = 4'h4,
        SQ_FALL = 4'h8
    } rpgs_seq_t;
endpackage

// >>> verilog/rpgs_hold_timer.sv
// qualifies a level as stable for a number of millisecond ticks
`timescale 1ns/1ps
module rpgs_hold_timer #(
    parameter int CW = 9
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic tick,
    input wire logic ok,
    input wire logic [CW-1:0] limit,
    output logic done
);
    logic [CW-1:0] cnt_reg;

    // any drop restarts the whole wait
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= '0;
        end else if (!ok) begin
            cnt_reg <= '0;
        end else if (tick && cnt_reg <= limit) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            done <= 1'b0;
        end else begin
            // one extra tick: the first may land just after ok rises
            done <= ok && (cnt_reg > limit);
        end
    end
endmodule

// >>> verilog/rpgs_top.sv
// rail power-good supervision, enable control and power sequencing
`timescale 1ns/1ps
// Function
// - status bit 7 shows reset comparator below
// - two-bit field selects 20/100/200/400 ms delay
// - five status bits mirror each rail good
// - pair mask: low when buck3 and lr1 fail
// - per-rail mask pulls power-good low on failure
// - rail runs only with enable bit, and with pin too if not sequenced
// - enable bit forced default while its pin low
// - three-bit order select, power-down in reverse
// - code 000 starts buck2 only
// - code 001 starts buck2 and buck3 together
// - code 010 buck1, then buck2 and buck3
// - code 011 buck3, then buck2
// - code 100 lr2 first, then buck1 buck2
// - code 101 converters follow own pins only
// - code 110 buck1, buck2, buck3 in turn
// - code 111 bucks 1,2 over 1ms after lr2
// - code 111 external regulator before lr2
// - automatic order begins on entering on state
// - non-sequenced converters follow pins in on state
// - code 100 override starts buck3 with lr2, ignores pin
module rpgs_top #(
    parameter int unsigned MS_CYCLES = rpgs_pkg::MS_CYCLES,
    parameter logic [2:0] SEQ_RESET = rpgs_pkg::SEQ_DEFAULT,
    parameter logic [5:0] MASK_RESET = rpgs_pkg::MASK_DEFAULT
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire rpgs_pkg::rpgs_regreq_t reg_req,
    output logic [7:0] reg_rdata,
    input wire logic undervoltage_lockout,
    input wire logic on_state,
    input wire logic reset_cmp_below,
    input wire logic [4:0] rail_good,
    input wire logic [4:0] rail_enable_pin,
    input wire logic buck3_pin_override,
    output logic [4:0] rail_run,
    output logic external_regulator_enable,
    output logic rail_ok_output_o,
    output logic rail_ok_output_oe,
    output logic reset_out_n
);
    import rpgs_pkg::*;

    localparam int DW = $clog2(MS_CYCLES);

    logic [1:0] ok_delay_select;
    logic [5:0] rail_ok_mask;
    logic [4:0] ena_reg;
    logic [2:0] sequence_select;
    logic [DW-1:0] div_reg;
    logic ms_tick;
    rpgs_seq_t st_reg;
    logic [1:0] level_reg;
    logic [1:0] gap_reg;
    logic [5:0] grp_cur;
    logic [5:0] grp_next;
    logic [5:0] auto_set;
    logic [5:0] auto_on;
    logic [4:0] run_next;
    logic [8:0] limit_ms;
    logic pg_fail;
    logic pg_done;
    logic rst_done;
    logic gap_ok;
    logic wr_status;
    logic wr_mask;
    logic wr_ctrl;

    // groups of rails per order step: [5] ext, [4:0] rails
    function automatic logic [5:0] group_vec(input logic [2:0] code,
                                             input logic ovr,
                                             input logic [1:0] lvl);
        logic [5:0] g;
        g = 6'h00;
        case (code)
            SEQ_B2: begin
                if (lvl == 2'h1) g[RAIL_B2] = 1'b1;
            end
            SEQ_B2B3: begin
                if (lvl == 2'h1) g[RAIL_B2] = 1'b1;
                if (lvl == 2'h1) g[RAIL_B3] = 1'b1;
            end
            SEQ_B1_B2B3: begin
                if (lvl == 2'h1) g[RAIL_B1] = 1'b1;
                if (lvl == 2'h2) g[RAIL_B2] = 1'b1;
                if (lvl == 2'h2) g[RAIL_B3] = 1'b1;
            end
            SEQ_B3_B2: begin
                if (lvl == 2'h1) g[RAIL_B3] = 1'b1;
                if (lvl == 2'h2) g[RAIL_B2] = 1'b1;
            end
            SEQ_LR2_B1B2: begin
                if (lvl == 2'h1) g[RAIL_LR2] = 1'b1;
                if (lvl == 2'h1) g[RAIL_B3] = ovr;
                if (lvl == 2'h2) g[RAIL_B1] = 1'b1;
                if (lvl == 2'h2) g[RAIL_B2] = 1'b1;
            end
            SEQ_B1_B2_B3: begin
                if (lvl == 2'h1) g[RAIL_B1] = 1'b1;
                if (lvl == 2'h2) g[RAIL_B2] = 1'b1;
                if (lvl == 2'h3) g[RAIL_B3] = 1'b1;
            end
            SEQ_EXT_LR2_B1B2: begin
                if (lvl == 2'h1) g[GRP_EXT] = 1'b1;
                if (lvl == 2'h2) g[RAIL_LR2] = 1'b1;
                if (lvl == 2'h3) g[RAIL_B1] = 1'b1;
                if (lvl == 2'h3) g[RAIL_B2] = 1'b1;
            end
            default: g = 6'h00;
        endcase
        return g;
    endfunction

    function automatic logic [8:0] delay_ms(input logic [1:0] code);
        case (code)
            DLY_20: delay_ms = DLY20_MS;
            DLY_100: delay_ms = DLY100_MS;
            DLY_200: delay_ms = DLY200_MS;
            default: delay_ms = DLY400_MS;
        endcase
    endfunction

    assign wr_status = reg_req.wr && reg_req.addr == ADDR_STATUS;
    assign wr_mask = reg_req.wr && reg_req.addr == ADDR_MASK;
    assign wr_ctrl = reg_req.wr && reg_req.addr == ADDR_CTRL;

    // lockout reloads defaults and outranks any write
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ok_delay_select <= DLY_DEFAULT;
        end else if (undervoltage_lockout) begin
            ok_delay_select <= DLY_DEFAULT;
        end else if (wr_status) begin
            ok_delay_select <= reg_req.wdata[DLY_HI:DLY_LO];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rail_ok_mask <= MASK_RESET;
        end else if (undervoltage_lockout) begin
            rail_ok_mask <= MASK_RESET;
        end else if (wr_mask) begin
            rail_ok_mask <= reg_req.wdata[5:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sequence_select <= SEQ_RESET;
        end else if (undervoltage_lockout) begin
            sequence_select <= SEQ_RESET;
        end else if (wr_ctrl) begin
            sequence_select <= reg_req.wdata[SEQ_HI:SEQ_LO];
        end
    end

    // a low pin holds its enable bit at default over a write
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ena_reg <= ENA_DEFAULT;
        end else if (undervoltage_lockout) begin
            ena_reg <= ENA_DEFAULT;
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (!rail_enable_pin[i]) begin
                    ena_reg[i] <= ENA_DEFAULT[i];
                end else if (wr_ctrl) begin
                    ena_reg[i] <= reg_req.wdata[i];
                end
            end
        end
    end

    // read data is registered one cycle after the address
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_req.addr)
                ADDR_STATUS: reg_rdata <= {reset_cmp_below,
                    ok_delay_select, rail_good};
                ADDR_MASK: reg_rdata <= {2'h0, rail_ok_mask};
                ADDR_CTRL: reg_rdata <= {sequence_select, ena_reg};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_reg <= '0;
            ms_tick <= 1'b0;
        end else if (div_reg == DW'(MS_CYCLES - 1)) begin
            div_reg <= '0;
            ms_tick <= 1'b1;
        end else begin
            div_reg <= div_reg + 1'b1;
            ms_tick <= 1'b0;
        end
    end

    assign grp_cur = group_vec(sequence_select, buck3_pin_override,
                               level_reg);
    assign grp_next = group_vec(sequence_select, buck3_pin_override,
                                level_reg + 2'h1);
    assign gap_ok = !(sequence_select == SEQ_EXT_LR2_B1B2 &&
                      level_reg == LVL_GAP) || gap_reg >= SEQ_GAP_TICKS;

    // stepping waits on the current group being good, plus a ms gap after lr2 in code 111
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= SQ_OFF;
            level_reg <= 2'h0;
        end else begin
            case (st_reg)
                SQ_OFF: begin
                    if (on_state) st_reg <= SQ_RISE;
                end
                SQ_RISE: begin
                    if (!on_state) begin
                        st_reg <= SQ_FALL;
                    end else if (level_reg == LVL_MAX ||
                                 grp_next == 6'h00) begin
                        st_reg <= SQ_HOLD;
                    end else if ((grp_cur[4:0] & rail_good) ==
                                 grp_cur[4:0] && gap_ok) begin
                        level_reg <= level_reg + 2'h1;
                    end
                end
                SQ_HOLD: begin
                    if (!on_state) st_reg <= SQ_FALL;
                end
                SQ_FALL: begin
                    if (on_state) begin
                        st_reg <= SQ_RISE;
                    end else if (level_reg == 2'h0) begin
                        st_reg <= SQ_OFF;
                    end else if ((grp_cur[4:0] & rail_good) == 5'h00) begin
                        level_reg <= level_reg - 2'h1;
                    end
                end
                default: begin
                    st_reg <= SQ_OFF;
                    level_reg <= 2'h0;
                end
            endcase
        end
    end

    // counts whole ms ticks since lr2 was started
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gap_reg <= 2'h0;
        end else if (level_reg < LVL_GAP) begin
            gap_reg <= 2'h0;
        end else if (ms_tick && gap_reg < SEQ_GAP_TICKS) begin
            gap_reg <= gap_reg + 2'h1;
        end
    end

    always_comb begin
        auto_set = 6'h00;
        auto_on = 6'h00;
        for (int l = 1; l <= 3; l++) begin
            auto_set = auto_set | group_vec(sequence_select,
                buck3_pin_override, l[1:0]);
            // in fall the top group is already off so it drains first
            if (l[1:0] < level_reg ||
                (l[1:0] == level_reg && st_reg != SQ_FALL)) begin
                auto_on = auto_on | group_vec(sequence_select,
                    buck3_pin_override, l[1:0]);
            end
        end
    end

    // sequenced rails ignore their pins; others follow them
    generate
        for (genvar i = 0; i < 5; i++) begin : g_run
            assign run_next[i] = auto_set[i] ?
                (auto_on[i] && ena_reg[i]) :
                (rail_enable_pin[i] && ena_reg[i]);
        end
    endgenerate

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rail_run <= 5'h00;
            external_regulator_enable <= 1'b0;
        end else begin
            rail_run <= run_next;
            external_regulator_enable <= auto_on[GRP_EXT];
        end
    end

    assign pg_fail = |(rail_ok_mask[4:0] & ~rail_good) ||
        (rail_ok_mask[MASK_PAIR_BIT] && !rail_good[RAIL_B3] &&
         !rail_good[RAIL_LR1]);
    assign limit_ms = delay_ms(ok_delay_select);

    rpgs_hold_timer #(.CW(9)) u_pg_timer (
        .clk(clk),
        .arst_n(arst_n),
        .tick(ms_tick),
        .ok(!pg_fail),
        .limit(limit_ms),
        .done(pg_done)
    );

    rpgs_hold_timer #(.CW(9)) u_rst_timer (
        .clk(clk),
        .arst_n(arst_n),
        .tick(ms_tick),
        .ok(!reset_cmp_below),
        .limit(limit_ms),
        .done(rst_done)
    );

    // fail bypasses the timer so the pin drops without delay
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rail_ok_output_o <= 1'b0;
            rail_ok_output_oe <= 1'b1;
            reset_out_n <= 1'b0;
        end else begin
            rail_ok_output_o <= 1'b0;
            rail_ok_output_oe <= pg_fail || !pg_done;
            reset_out_n <= !reset_cmp_below && rst_done;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_release;
        $fell(rail_ok_output_oe);
    endsequence
    sequence s_qualified;
        $past(pg_done) && !$past(pg_fail);
    endsequence

    AST_RESET_FLAG: assert property (
        reg_req.addr == ADDR_STATUS |=>
        reg_rdata[STAT_RESET_BIT] == $past(reset_cmp_below))
        else $error("reset flag mismatch");
    AST_DELAY_WRITE: assert property (
        wr_status && !undervoltage_lockout |=>
        limit_ms == delay_ms($past(reg_req.wdata[DLY_HI:DLY_LO])))
        else $error("delay select not taken");
    AST_RAIL_STATUS: assert property (
        reg_req.addr == ADDR_STATUS |=>
        reg_rdata[4:0] == $past(rail_good))
        else $error("rail status mismatch");
    AST_PAIR_MASK: assert property (
        rail_ok_mask[MASK_PAIR_BIT] && !rail_good[RAIL_B3] &&
        !rail_good[RAIL_LR1] |=> rail_ok_output_oe)
        else $error("pair failure not pulling low");
    AST_RAIL_MASK: assert property (
        |(rail_ok_mask[4:0] & ~rail_good) |=> rail_ok_output_oe)
        else $error("masked rail failure not pulling low");
    AST_RUN_ENABLE: assert property (
        ##1 (rail_run & ~$past(ena_reg)) == 5'h00)
        else $error("rail runs without enable bit");
    AST_PIN_DEFAULT: assert property (
        ##1 (~$past(rail_enable_pin) & (ena_reg ^ ENA_DEFAULT)) == 5'h00)
        else $error("enable bit not held at default");
    AST_FALL_ENTRY: assert property (
        st_reg == SQ_HOLD && !on_state |=> st_reg == SQ_FALL)
        else $error("power-down not started");
    AST_ORDER_110: assert property (
        st_reg == SQ_RISE && on_state &&
        sequence_select == SEQ_B1_B2_B3 && level_reg == 2'h1 &&
        rail_good[RAIL_B1] |=> level_reg == 2'h2)
        else $error("buck2 not started after buck1 good");
    AST_EXT_FIRST: assert property (
        $past(sequence_select) == SEQ_EXT_LR2_B1B2 &&
        rail_run[RAIL_LR2] && $past(auto_set[RAIL_LR2]) |->
        external_regulator_enable)
        else $error("lr2 started before external regulator");
    AST_PG_RELEASE: assert property (
        s_release |-> s_qualified)
        else $error("power-good released early");
endmodule

// >>> tb/rpgs_rail_model.sv
// rail plant model: each rail reads good a fixed lag after its enable
`timescale 1ns/1ps
module rpgs_rail_model #(
    parameter int LAG = 5
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [4:0] run,
    input wire logic [4:0] kill,
    output logic [4:0] good
);
    int cnt [5];

    // good lags enable to mimic soft start, so ordering is observable
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            good <= 5'h00;
            for (int i = 0; i < 5; i++) begin
                cnt[i] <= 0;
            end
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (!run[i] || kill[i]) begin
                    cnt[i] <= 0;
                    good[i] <= 1'b0;
                end else if (cnt[i] < LAG) begin
                    cnt[i] <= cnt[i] + 1;
                end else begin
                    good[i] <= 1'b1;
                end
            end
        end
    end
endmodule

// >>> tb/tb.sv
// register, sequencing and power-good bench for the rail supervisor
`timescale 1ns/1ps
module tb;
    import rpgs_pkg::*;
    localparam int MSC = 10;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    rpgs_regreq_t reg_req = '0;
    logic [7:0] reg_rdata;
    logic undervoltage_lockout = 1'b0;
    logic on_state = 1'b0;
    logic reset_cmp_below = 1'b1;
    logic [4:0] rail_good;
    logic [4:0] rail_run;
    logic [4:0] rail_enable_pin = 5'h03; // buck pins tied low
    logic [4:0] kill = 5'h00;
    logic buck3_pin_override = 1'b0;
    logic external_regulator_enable;
    logic rail_ok_output_oe;
    logic rail_ok_output_o;
    logic reset_out_n;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    int k;
    logic [7:0] rd;
    logic [7:0] exp_run [9] = '{8'h04, 8'h06, 8'h0E, 8'h06, 8'h0D,
        8'h00, 8'h0E, 8'h0D, 8'h0F};

    always #4 clk = ~clk;

    rpgs_top #(.MS_CYCLES(MSC)) rpgs_top_i (
        .clk(clk),
        .arst_n(arst_n),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .undervoltage_lockout(undervoltage_lockout),
        .on_state(on_state),
        .reset_cmp_below(reset_cmp_below),
        .rail_good(rail_good),
        .rail_enable_pin(rail_enable_pin),
        .buck3_pin_override(buck3_pin_override),
        .rail_run(rail_run),
        .external_regulator_enable(external_regulator_enable),
        .rail_ok_output_o(rail_ok_output_o),
        .rail_ok_output_oe(rail_ok_output_oe),
        .reset_out_n(reset_out_n)
    );

    rpgs_rail_model #(.LAG(5)) rpgs_rail_model_i (
        .clk(clk),
        .arst_n(arst_n),
        .run(rail_run),
        .kill(kill),
        .good(rail_good)
    );

    task automatic finish_test();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // strobe drops for one cycle so back-to-back calls never collide
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_req = '{1'b1, a, d};
        @(negedge clk);
        reg_req.wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic rd8(input logic [7:0] a, output logic [7:0] d);
        reg_req.addr = a;
        @(negedge clk);
        d = reg_rdata;
    endtask

    task automatic wait_run(input int b, input logic v);
        for (int i = 0; i < 200 && rail_run[b] !== v; i++)
            @(negedge clk);
    endtask

    task automatic wait_ok(output int n);
        for (n = 0; n < 400 && rail_ok_output_oe !== 1'b0; n++)
            @(negedge clk);
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_errors++;
            finish_test();
        end
    end

    initial begin
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        rd8(ADDR_MASK, rd);
        chk8(rd, 8'h08);
        rd8(ADDR_CTRL, rd);
        chk8(rd, 8'h1F);
        rd8(8'h0A, rd);
        chk8(rd, 8'h00);
        repeat (20) @(negedge clk);
        rd8(ADDR_STATUS, rd);
        chk8(rd, 8'hE3);
        reset_cmp_below = 1'b0;
        rd8(ADDR_STATUS, rd);
        chk8(rd, 8'h63);
        wr(ADDR_MASK, 8'hFF);
        rd8(ADDR_MASK, rd);
        chk8(rd, 8'h3F);
        undervoltage_lockout = 1'b1;
        @(negedge clk);
        undervoltage_lockout = 1'b0;
        rd8(ADDR_MASK, rd);
        chk8(rd, 8'h08);
        wr(ADDR_STATUS, 8'hFF);
        rd8(ADDR_STATUS, rd);
        chk8(rd, 8'h63);
        wr(ADDR_STATUS, 8'h00);
        rd8(ADDR_STATUS, rd);
        chk8(rd, 8'h03);
        wr(ADDR_CTRL, 8'h1D);
        rd8(ADDR_CTRL, rd);
        chk8(rd, 8'h1D);
        repeat (3) @(negedge clk);
        chk1(rail_run[1], 1'b0);
        rail_enable_pin[1] = 1'b0;
        @(negedge clk);
        rd8(ADDR_CTRL, rd);
        chk8(rd, 8'h1F);
        rail_enable_pin[1] = 1'b1;
        repeat (3) @(negedge clk);
        chk1(rail_run[1], 1'b1);
        wr(ADDR_MASK, 8'h1F);
        wr(ADDR_CTRL, 8'hDF);
        on_state = 1'b1;
        wait_run(4, 1'b1);
        chk1(rail_run[3], 1'b0);
        wait_run(3, 1'b1);
        chk1(rail_good[4], 1'b1);
        chk1(rail_run[2], 1'b0);
        wait_run(2, 1'b1);
        chk1(rail_good[3], 1'b1);
        chk1(rail_ok_output_oe, 1'b1);
        wait_ok(k);
        chk1(k >= 20 * MSC && k <= 20 * MSC + 30, 1'b1);
        rd8(ADDR_STATUS, rd);
        chk8(rd, 8'h1F);
        chk1(rail_ok_output_o, 1'b0);
        kill = 5'h02;
        repeat (3) @(negedge clk);
        chk1(rail_ok_output_oe, 1'b1);
        kill = 5'h00;
        wr(ADDR_MASK, 8'h20);
        wait_ok(k);
        kill = 5'h02;
        repeat (3) @(negedge clk);
        chk1(rail_ok_output_oe, 1'b0);
        kill = 5'h06;
        repeat (3) @(negedge clk);
        chk1(rail_ok_output_oe, 1'b1);
        kill = 5'h00;
        chk1(reset_out_n, 1'b1);
        reset_cmp_below = 1'b1;
        repeat (3) @(negedge clk);
        chk1(reset_out_n, 1'b0);
        on_state = 1'b0;
        wait_run(2, 1'b0);
        chk1(rail_run[3], 1'b1);
        wait_run(3, 1'b0);
        chk1(rail_run[4], 1'b1);
        wait_run(4, 1'b0);
        rail_enable_pin = 5'h02;
        for (int c = 0; c < 9; c++) begin
            buck3_pin_override = (c == 8);
            wr(ADDR_CTRL, {(c == 8) ? 3'h4 : c[2:0], 5'h1F});
            on_state = 1'b1;
            if (c == 7) begin
                for (k = 0; k < 50 && external_regulator_enable !== 1'b1; k++)
                    @(negedge clk);
                chk1(rail_run[0], 1'b0);
                wait_run(0, 1'b1);
                for (k = 0; k < 100 && rail_run[4] !== 1'b1; k++)
                    @(negedge clk);
                chk1(k > MSC, 1'b1);
            end
            repeat (80) @(negedge clk);
            rd = {4'h0, rail_run[4:2], rail_run[0]};
            chk8(rd, exp_run[c]);
            on_state = 1'b0;
            repeat (80) @(negedge clk);
        end
        finish_test();
    end
endmodule
